// *** design/msd_regs.svh ***
// Purpose: Constants for the microstep dispatch and return stack block
// Assumes: Included by bare name
// Notes: Word fields are numbered from bit 31, which is opcode bit zero
`ifndef MSD_REGS_SVH
`define MSD_REGS_SVH
`define WCS_WORDS 16'h0200
`define WCS_HALF 256
`define FCS_BASE 16'h0200
`define FCS_WORDS 16'h0080
`define FCS_HALF 64
`define FCS_RET 33'h0_A000_0000
`define STK_DEPTH 16
`define STK_FIRST 4'h1
`define STK_LAST_FREE 4'hE
`define STK_EMPTY 4'h0
`define PTR_SP 4'h6
`define VEC_FULL 16'h0200
`define VEC_UNDER 16'h0210
`define VEC_ACTION 16'h0220
`define F_PAR 32
`define F_CLASS 31
`define F_LIT 30
`define F_WAIT 29
`define F_CTL 30:28
`define F_ENTRY 27
`define F_INV 19
`define F_SEL 18:16
`define F_TGT 15:0
`define R_CTRL 8'h00
`define R_STAT 8'h04
`define R_CADDR 8'h08
`define R_COND 8'h0C
`define R_LOAD 8'h10
`define R_PTR_HI 2'h1
`define B_RUN 0
`define B_LOCK 1
`define B_FULL 1
`define B_UNDER 2
`define B_PERR 3
`define B_BLT 4
`endif

// *** design/msd_pkg.sv ***
// Purpose: Types shared by the dispatch core and the return stack
// Assumes: msd_regs.svh supplies the sizes
// Notes: Store arrays live inside the core state struct
`include "msd_regs.svh"
package msd_pkg;
	typedef enum logic [2:0] {SEQ_STOP = 3'b001, SEQ_RUN = 3'b010, SEQ_BREAK = 3'b100} seq_e;
	typedef enum logic [2:0] {CO_BRANCH = 3'h0, CO_ENTER = 3'h1, CO_RETURN = 3'h2,
		CO_EXT = 3'h3, CO_BLOCK = 3'h4} ctl_op_e;
	typedef logic [32:0] cs_word_t;
	typedef struct packed {
		logic [`STK_DEPTH-1:0][15:0] ent;
		logic [7:0] sp;
	} stack_s;
	typedef struct packed {
		logic [31:0] rdata;
		logic wait_req;
		logic run;
		logic lock;
		logic [7:0] cond;
		logic [4:1] stat;
		logic [31:0] blt_data;
		seq_e seq;
		logic [15:0] cur_addr;
		logic [15:0] brk_addr;
		logic [15:0] brk_vec;
		logic [7:0][7:0] ptr;
		logic [31:0] op_gate;
		logic op_valid;
		logic [31:0] ctl_gate;
		logic ctl_valid;
		logic [31:0] lit;
		logic lit_valid;
		logic [`WCS_HALF-1:0][32:0] even_mem;
		logic [`WCS_HALF-1:0][32:0] odd_mem;
		logic [6:0][7:0] ce1;
		logic [6:0][7:0] ce2;
		logic [7:0] oe1;
		logic [7:0] oe2;
		logic [15:0] we1;
		logic [15:0] we2;
		logic ar1;
		logic ar2;
		logic ar3;
	} core_s;
endpackage

// *** design/stack_if.sv ***
// Purpose: Control and data between dispatch core and return stack
// Assumes: Single clock domain
// Notes: Core drives requests, stack answers combinationally
`timescale 1ns/1ps
`default_nettype none
interface stack_if;
	logic push;
	logic pop;
	logic ld_sp;
	logic wr_base;
	logic [15:0] push_addr;
	logic [15:0] base_addr;
	logic [7:0] sp_load;
	logic [15:0] top;
	logic [7:0] sp;
	logic full_evt;
	modport ctrl(output push, pop, ld_sp, wr_base, push_addr, base_addr, sp_load,
		input top, sp, full_evt);
	modport stk(input push, pop, ld_sp, wr_base, push_addr, base_addr, sp_load,
		output top, sp, full_evt);
endinterface
`default_nettype wire

// *** design/return_stack.sv ***
// Purpose: Sixteen-entry subroutine return stack with 8-bit pointer
// Assumes: Core never asks push and pop in the same cycle
// Notes: Upper pointer bits are left for service routines
`timescale 1ns/1ps
`default_nettype none
`include "msd_regs.svh"
module return_stack (
	input wire logic mclk,
	input wire logic rst_n,
	stack_if.stk stk
);
	msd_pkg::stack_s r;
	msd_pkg::stack_s n;

	always_comb begin
		n = r;
		if (stk.ld_sp) begin
			n.sp = stk.sp_load;
		end else if (stk.push) begin
			// Pointer moves and entry is written together
			n.sp = r.sp + 8'h01; // RQ24 RQ17 RQ20
			n.ent[n.sp[3:0]] = stk.push_addr; // RQ13 RQ14
		end else if (stk.pop) begin
			n.sp = r.sp - 8'h01; // RQ15 RQ19
		end
		if (stk.wr_base) begin
			n.ent[`STK_EMPTY] = stk.base_addr; // RQ18 RQ19
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign stk.sp = r.sp;
	assign stk.top = r.ent[r.sp[3:0]]; // RQ16
	assign stk.full_evt = stk.push && !stk.ld_sp && (r.sp[3:0] == `STK_LAST_FREE); // RQ18

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_FIRST_PUSH: assert property (stk.push && !stk.ld_sp && r.sp[3:0] == `STK_EMPTY
		|=> r.sp[3:0] == `STK_FIRST) else $error("first push missed location 1"); // RQ17
	AST_TOP_WRITE: assert property (stk.push && !stk.ld_sp && !stk.wr_base
		|=> stk.top == $past(stk.push_addr)) else $error("pushed address not on top"); // RQ24
endmodule
`default_nettype wire

// *** design/microstep_dispatch.sv ***
// Summary of operation
// RQ1 - Even and odd banks fetched as pair
// RQ2 - Writable store: 512 words, 32 bits plus parity
// RQ3 - Writable store loaded by block transfer step
// RQ4 - Fixed store 128 words, never written
// RQ5 - Lower address word is current, other successor
// RQ6 - Opcode bit zero picks operating or control
// RQ7 - Operating then control: both execute together
// RQ8 - Long literal successor feeds operand B
// RQ9 - Wait step suppresses successor, branches even
// RQ10 - Control current executes alone
// RQ11 - Two operating words: only current dispatched
// RQ12 - No branch: address advances by one
// RQ13 - Return stack: sixteen 16-bit entries
// RQ14 - Push on enter branches and breakouts
// RQ15 - Untaken branch-or-return pops and returns
// RQ16 - Pointer 06 addresses top, zero means empty
// RQ17 - First push writes location 01, ascending
// RQ18 - Writing 15 forces full breakout next clock
// RQ19 - Empty return without lockout forces underflow
// RQ20 - Stack pointer is eight bits wide
// RQ21 - Pointers 00-07 count, 08-15 are sense lines
// RQ22 - Pointer roles: sequence, general, shift, boards
// RQ23 - Pseudo-pointer 15 from operating engine boards
// RQ24 - Push increments pointer and writes new top
//
// Purpose: Control store pair fetch, dispatch, sequencing and pointers
// Assumes: Avalon-MM slave with waitrequest, byte address, 32-bit data
// Notes: Paired execution advances by two; every output is registered
`timescale 1ns/1ps
`default_nettype none
`include "msd_regs.svh"
module microstep_dispatch (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [6:0][7:0] ce_board,
	input wire logic [7:0] oe_board,
	input wire logic [15:0] wait_entry,
	input wire logic action_req,
	output logic [31:0] op_gate,
	output logic op_valid,
	output logic [31:0] ctl_gate,
	output logic ctl_valid,
	output logic [31:0] lit_data,
	output logic lit_valid,
	output logic [15:0] cur_addr
);
	msd_pkg::core_s r;
	msd_pkg::core_s n;
	stack_if stk();
	msd_pkg::cs_word_t w0;
	msd_pkg::cs_word_t w1;
	logic act_edge;
	logic go;

	return_stack u_stack (
		.mclk(mclk),
		.rst_n(rst_n),
		.stk(stk)
	);

	// Banks are independent, so an odd current address reads both halves at once
	function automatic msd_pkg::cs_word_t cs_read(input msd_pkg::core_s s,
		input logic [15:0] a);
		msd_pkg::cs_word_t w;
		w = '0;
		if (a < `WCS_WORDS) begin
			w = a[0] ? s.odd_mem[a[8:1]] : s.even_mem[a[8:1]]; // RQ1 RQ2
		end else if (a - `FCS_BASE < `FCS_WORDS) begin
			// Fixed words are constants; only the return word is placed
			if (a[3:0] == 4'h0) begin
				w = `FCS_RET; // RQ4
			end
		end
		return w;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return m;
	endfunction

	assign w0 = cs_read(r, r.cur_addr); // RQ5
	assign w1 = cs_read(r, r.cur_addr + 16'h0001); // RQ5
	assign act_edge = r.ar2 && !r.ar3;
	assign go = (r.seq == msd_pkg::SEQ_RUN) && r.run && !act_edge;

	always_comb begin
		logic bus_wr;
		logic [31:0] wv;
		logic [3:0] pi;
		logic [15:0] ld_a;
		logic [15:0] nxt;
		logic [15:0] ctl_a;
		logic [31:0] cw;
		logic do_ctl;
		logic taken;
		logic blt_go;
		logic [3:1] evt;
		bus_wr = avs_write && !r.wait_req;
		wv = '0;
		pi = avs_address[5:2];
		ld_a = {r.ptr[1], r.ptr[0]};
		nxt = r.cur_addr + 16'h0001;
		ctl_a = r.cur_addr;
		cw = '0;
		do_ctl = 1'b0;
		taken = 1'b0;
		blt_go = 1'b0;
		evt = '0;
		n = r;
		stk.push = 1'b0;
		stk.pop = 1'b0;
		stk.ld_sp = 1'b0;
		stk.wr_base = 1'b0;
		stk.push_addr = '0;
		stk.base_addr = '0;
		stk.sp_load = '0;
		n.ce1 = ce_board;
		n.ce2 = r.ce1;
		n.oe1 = oe_board;
		n.oe2 = r.oe1;
		n.we1 = wait_entry;
		n.we2 = r.we1;
		n.ar1 = action_req;
		n.ar2 = r.ar1;
		n.ar3 = r.ar2;
		n.op_valid = 1'b0;
		n.ctl_valid = 1'b0;
		n.lit_valid = 1'b0;

		// Answer one cycle after the request; write acts at the release edge
		n.wait_req = 1'b1;
		if ((avs_read || avs_write) && r.wait_req) begin
			n.wait_req = 1'b0;
			n.rdata = '0;
			if (avs_address == `R_CTRL) begin
				n.rdata[`B_RUN] = r.run;
				n.rdata[`B_LOCK] = r.lock;
			end else if (avs_address == `R_STAT) begin
				n.rdata[4:1] = r.stat;
				n.rdata[`B_RUN] = (r.seq != msd_pkg::SEQ_STOP);
			end else if (avs_address == `R_CADDR) begin
				n.rdata[15:0] = r.cur_addr;
			end else if (avs_address == `R_COND) begin
				n.rdata[7:0] = r.cond;
			end else if (avs_address == `R_LOAD) begin
				n.rdata = r.blt_data;
			end else if (avs_address[7:6] == `R_PTR_HI) begin
				if (pi == `PTR_SP) begin
					n.rdata[7:0] = stk.sp; // RQ16
				end else if (pi[3]) begin
					// Pseudo-pointers have no counter; 15 comes from the other engine
					n.rdata[7:0] = (pi == 4'hF) ? r.oe2 : r.ce2[pi[2:0]]; // RQ21 RQ22 RQ23
				end else begin
					n.rdata[7:0] = r.ptr[pi[2:0]]; // RQ21 RQ22
				end
			end
		end

		// A staged word commits on a block step, or at once while stopped
		blt_go = r.stat[`B_BLT] && (r.seq == msd_pkg::SEQ_STOP);

		case (r.seq)
			msd_pkg::SEQ_STOP: begin
				if (r.run) begin
					n.seq = msd_pkg::SEQ_RUN;
				end
			end
			msd_pkg::SEQ_RUN: begin
				if (!r.run) begin
					n.seq = msd_pkg::SEQ_STOP;
				end else if (act_edge) begin
					stk.push = 1'b1; // RQ14
					stk.push_addr = r.cur_addr;
					n.cur_addr = `VEC_ACTION;
				end else begin
					if (^w0) begin
						evt[`B_PERR] = 1'b1;
					end
					if (w0[`F_CLASS]) begin
						do_ctl = 1'b1; // RQ6 RQ10
						cw = w0[31:0];
					end else begin
						n.op_gate = w0[31:0]; // RQ6 RQ11
						n.op_valid = 1'b1;
						if (w0[`F_LIT]) begin
							n.lit = w1[31:0]; // RQ8
							n.lit_valid = 1'b1;
							nxt = r.cur_addr + 16'h0002;
						end else if (w0[`F_WAIT]) begin
							nxt = {r.we2[15:1], 1'b0}; // RQ9
						end else if (w1[`F_CLASS]) begin
							do_ctl = 1'b1; // RQ7
							cw = w1[31:0];
							ctl_a = r.cur_addr + 16'h0001;
							nxt = r.cur_addr + 16'h0002;
						end
					end
					if (do_ctl) begin
						n.ctl_gate = cw;
						n.ctl_valid = 1'b1;
						taken = r.cond[cw[`F_SEL]] ^ cw[`F_INV];
						case (cw[`F_CTL])
							msd_pkg::CO_BRANCH: begin
								if (taken) begin
									nxt = cw[`F_TGT];
								end
							end
							msd_pkg::CO_ENTER: begin
								if (taken) begin
									stk.push = 1'b1; // RQ14
									stk.push_addr = ctl_a + 16'h0001;
									nxt = cw[`F_TGT];
								end
							end
							msd_pkg::CO_EXT: begin
								if (taken) begin
									stk.push = cw[`F_ENTRY]; // RQ14
									stk.push_addr = ctl_a + 16'h0001;
									nxt = cw[`F_TGT];
								end
							end
							msd_pkg::CO_RETURN: begin
								if (taken) begin
									nxt = cw[`F_TGT];
								end else begin
									stk.pop = 1'b1; // RQ15
									nxt = stk.top;
									if (stk.sp[3:0] == `STK_EMPTY && !r.lock) begin
										n.seq = msd_pkg::SEQ_BREAK; // RQ19
										n.brk_addr = ctl_a;
										n.brk_vec = `VEC_UNDER;
										evt[`B_UNDER] = 1'b1;
									end
								end
							end
							msd_pkg::CO_BLOCK: begin
								blt_go = r.stat[`B_BLT]; // RQ3
							end
							default: begin
							end
						endcase
					end
					n.cur_addr = nxt; // RQ12
				end
				// Any push that fills location 15 breaks out, action pushes too
				if (stk.full_evt) begin
					n.seq = msd_pkg::SEQ_BREAK; // RQ18
					n.brk_addr = n.cur_addr;
					n.brk_vec = `VEC_FULL;
					evt[`B_FULL] = 1'b1;
				end
			end
			msd_pkg::SEQ_BREAK: begin
				stk.wr_base = 1'b1; // RQ18 RQ19
				stk.base_addr = r.brk_addr;
				n.cur_addr = r.brk_vec;
				n.seq = msd_pkg::SEQ_RUN;
			end
			default: begin
				n.seq = msd_pkg::SEQ_STOP;
			end
		endcase
		n.stat[3:1] = r.stat[3:1] | evt;

		// Only the writable range accepts words; fixed store has no write path
		if (blt_go) begin
			if (ld_a < `WCS_WORDS) begin
				if (ld_a[0]) begin
					n.odd_mem[ld_a[8:1]] = {^r.blt_data, r.blt_data}; // RQ2 RQ3
				end else begin
					n.even_mem[ld_a[8:1]] = {^r.blt_data, r.blt_data}; // RQ2 RQ3
				end
			end
			{n.ptr[1], n.ptr[0]} = ld_a + 16'h0001; // RQ22
			n.ptr[2] = r.ptr[2] - 8'h01; // RQ22
			n.stat[`B_BLT] = 1'b0;
		end

		if (bus_wr) begin
			if (avs_address == `R_CTRL) begin
				wv = merge({30'h0, r.lock, r.run}, avs_writedata, avs_byteenable);
				n.run = wv[`B_RUN];
				n.lock = wv[`B_LOCK];
			end else if (avs_address == `R_STAT) begin
				wv = merge('0, avs_writedata, avs_byteenable);
				// A set from this same cycle wins over the clear
				n.stat[3:1] = (r.stat[3:1] & ~wv[3:1]) | evt;
			end else if (avs_address == `R_CADDR && r.seq == msd_pkg::SEQ_STOP) begin
				wv = merge({16'h0, r.cur_addr}, avs_writedata, avs_byteenable);
				n.cur_addr = wv[15:0];
			end else if (avs_address == `R_COND) begin
				wv = merge({24'h0, r.cond}, avs_writedata, avs_byteenable);
				n.cond = wv[7:0];
			end else if (avs_address == `R_LOAD) begin
				n.blt_data = merge(r.blt_data, avs_writedata, avs_byteenable);
				n.stat[`B_BLT] = 1'b1;
			end else if (avs_address[7:6] == `R_PTR_HI && !pi[3] && avs_byteenable[0]) begin
				if (pi == `PTR_SP) begin
					stk.ld_sp = 1'b1;
					stk.sp_load = avs_writedata[7:0];
				end else begin
					n.ptr[pi[2:0]] = avs_writedata[7:0];
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.wait_req <= 1'b1;
			r.seq <= msd_pkg::SEQ_STOP;
		end else begin
			r <= n;
		end
	end

	assign avs_readdata = r.rdata;
	assign avs_waitrequest = r.wait_req;
	assign op_gate = r.op_gate;
	assign op_valid = r.op_valid;
	assign ctl_gate = r.ctl_gate;
	assign ctl_valid = r.ctl_valid;
	assign lit_data = r.lit;
	assign lit_valid = r.lit_valid;
	assign cur_addr = r.cur_addr;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_WAIT_EVEN: assert property (go && !w0[`F_CLASS] && !w0[`F_LIT] && w0[`F_WAIT]
		|=> !ctl_valid && !cur_addr[0]) else $error("wait step not even or not alone"); // RQ9
	AST_LIT_OPERAND: assert property (go && !w0[`F_CLASS] && w0[`F_LIT]
		|=> lit_valid && !ctl_valid && lit_data == $past(w1[31:0])) else $error("literal lost"); // RQ8
	AST_CTL_ALONE: assert property (go && w0[`F_CLASS]
		|=> ctl_valid && !op_valid && ctl_gate == $past(w0[31:0])) else $error("control not alone"); // RQ10
	AST_PAIR: assert property (go && !w0[`F_CLASS] && !w0[`F_LIT] && !w0[`F_WAIT] && w1[`F_CLASS]
		|=> op_valid && ctl_valid && ctl_gate == $past(w1[31:0])) else $error("pair not issued"); // RQ7
	AST_OPS_ONE: assert property (go && !w0[`F_CLASS] && !w0[`F_LIT] && !w0[`F_WAIT]
		&& !w1[`F_CLASS] |=> op_valid && !ctl_valid && cur_addr == $past(cur_addr) + 16'h0001)
		else $error("two operating words misdispatched"); // RQ11 RQ12
	AST_FULL: assert property (go && stk.full_evt |=> r.seq == msd_pkg::SEQ_BREAK
		##1 cur_addr == `VEC_FULL) else $error("stack full breakout missing"); // RQ18
	AST_UNDER: assert property (go && stk.pop && stk.sp[3:0] == `STK_EMPTY && !r.lock
		|=> r.seq == msd_pkg::SEQ_BREAK ##1 cur_addr == `VEC_UNDER)
		else $error("underflow breakout missing"); // RQ19
	AST_SP_DROP: assert property (go && stk.pop && !stk.wr_base |=> stk.sp == $past(stk.sp) - 8'h01)
		else $error("return did not pop"); // RQ15
	COV_PAIR: cover property (op_valid && ctl_valid);
	COV_LIT: cover property (lit_valid);
	COV_FULL: cover property (r.seq == msd_pkg::SEQ_BREAK && r.brk_vec == `VEC_FULL);
endmodule
`default_nettype wire

// *** tb/microstep_dispatch_and_return_stack_tb.sv ***
// Purpose: Self-checking bench for the dispatch core and its return stack
// Assumes: Bus answers come one cycle after a request is taken
// Notes: Programs are staged through the load register while stopped; t_push stages one word while running
`timescale 1ns/1ps
`default_nettype none
module microstep_dispatch_and_return_stack_tb;
	logic mclk;
	logic rst_n;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [6:0][7:0] ce_board;
	logic [7:0] oe_board;
	logic [15:0] wait_entry;
	logic action_req;
	logic [31:0] op_gate;
	logic op_valid;
	logic [31:0] ctl_gate;
	logic ctl_valid;
	logic [31:0] lit_data;
	logic lit_valid;
	logic [15:0] cur_addr;
	int fails = 0;
	int check_count = 0;
	logic logging = 1'b0;
	logic [2:0] q_kind[$];
	logic [31:0] q_word[$];

	microstep_dispatch dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ce_board(ce_board), .oe_board(oe_board),
		.wait_entry(wait_entry), .action_req(action_req), .op_gate(op_gate),
		.op_valid(op_valid), .ctl_gate(ctl_gate), .ctl_valid(ctl_valid),
		.lit_data(lit_data), .lit_valid(lit_valid), .cur_addr(cur_addr));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Log every dispatch in order so pairing can be judged afterwards
	always @(posedge mclk) begin
		if (logging === 1'b1) begin
			if (op_valid | ctl_valid | lit_valid)
				q_kind.push_back({op_valid, ctl_valid, lit_valid});
			if (op_valid)
				q_word.push_back(op_gate);
			if (ctl_valid)
				q_word.push_back(ctl_gate);
			if (lit_valid)
				q_word.push_back(lit_data);
		end
	end

	task end_sim;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Entered just after a rising edge; holds the request until waitrequest is low
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			n++;
			@(posedge mclk);
		end
		if (n >= 50)
			fails++;
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask

	task put(input logic [15:0] a, input logic [31:0] w);
		wr(8'h40, {24'h0, a[7:0]});
		wr(8'h44, {24'h0, a[15:8]});
		wr(8'h10, w);
	endtask

	task go(input logic [15:0] a, input logic lock);
		wr(8'h08, {16'h0, a});
		wr(8'h00, {30'h0, lock, 1'b1});
	endtask

	task halt;
		wr(8'h00, 32'h0);
	endtask

	task wait_addr(input logic [15:0] a);
		int n;
		n = 0;
		while (cur_addr !== a && n < 300) begin
			n++;
			@(posedge mclk);
		end
		chk({16'h0, cur_addr}, {16'h0, a});
	endtask

	task t_reset;
		chk({16'h0, cur_addr}, 32'h0);
		chk({29'h0, op_valid, ctl_valid, lit_valid}, 32'h0);
		rd_chk(8'h04, 32'hFFFF_FFFF, 32'h0);
		rd_chk(8'h58, 32'hFF, 32'h0);
		rd_chk(8'h30, 32'hFFFF_FFFF, 32'h0);
	endtask

	task t_ptrs;
		wr(8'h50, 32'hA5);
		rd_chk(8'h50, 32'hFF, 32'hA5);
		wr(8'h64, 32'h00);
		rd_chk(8'h64, 32'hFF, 32'h81);
		rd_chk(8'h78, 32'hFF, 32'h86);
		rd_chk(8'h7C, 32'hFF, 32'h5C);
		wr(8'h58, 32'hF0);
		rd_chk(8'h58, 32'hFF, 32'hF0);
		wr(8'h58, 32'h00);
	endtask

	// Two operating words, op+ctl pair, literal, enter, return, wait step, then a branch loop
	task t_dispatch;
		logic [31:0] prog[9];
		logic [2:0] ek[8];
		logic [31:0] ew[10];
		prog = '{32'h0000_0011, 32'h0000_0022, 32'h8000_0010, 32'h4000_0033, 32'h1234_5678,
			32'h9008_0008, 32'h0000_0066, 32'h2000_0077, 32'hA000_0000};
		ek = '{3'h4, 3'h6, 3'h5, 3'h2, 3'h2, 3'h4, 3'h4, 3'h2};
		ew = '{prog[0], prog[1], prog[2], prog[3], prog[4], prog[5], prog[8], prog[6],
			prog[7], 32'h8008_0020};
		for (int i = 0; i < 9; i++)
			put(i[15:0], prog[i]);
		put(16'h0020, 32'h8008_0020);
		wr(8'h0C, 32'h0);
		q_kind.delete();
		q_word.delete();
		logging = 1'b1;
		go(16'h0000, 1'b0);
		repeat (30) @(posedge mclk);
		logging = 1'b0;
		halt;
		for (int i = 0; i < 8; i++)
			chk({29'h0, q_kind[i]}, {29'h0, ek[i]});
		for (int i = 0; i < 10; i++)
			chk(q_word[i], ew[i]);
		rd_chk(8'h58, 32'hFF, 32'h0);
		rd_chk(8'h04, 32'h8, 32'h0);
	endtask

	// Extended branch with entry bit, then a block step commits a word staged while running
	task t_push;
		put(16'h0050, 32'hB808_0058);
		put(16'h0058, 32'hC000_0000);
		put(16'h0059, 32'h8008_0058);
		wr(8'h40, 32'h70);
		wr(8'h44, 32'h0);
		wr(8'h48, 32'h5);
		wr(8'h58, 32'h0);
		go(16'h0050, 1'b0);
		repeat (10) @(posedge mclk);
		wr(8'h10, 32'h8008_0070);
		repeat (10) @(posedge mclk);
		halt;
		rd_chk(8'h58, 32'hFF, 32'h1);
		rd_chk(8'h40, 32'hFF, 32'h71);
		rd_chk(8'h48, 32'hFF, 32'h4);
		rd_chk(8'h04, 32'h10, 32'h0);
		go(16'h0070, 1'b0);
		repeat (10) @(posedge mclk);
		chk({16'h0, cur_addr}, 32'h70);
		halt;
	endtask

	// Self-entering branch pushes every cycle until the stack fills
	task t_full;
		put(16'h0040, 32'h9008_0040);
		wr(8'h58, 32'h0);
		go(16'h0040, 1'b0);
		wait_addr(16'h0200);
		halt;
		rd_chk(8'h04, 32'h2, 32'h2);
	endtask

	task t_under;
		put(16'h0060, 32'hA000_0000);
		wr(8'h58, 32'h0);
		go(16'h0060, 1'b0);
		wait_addr(16'h0210);
		halt;
		rd_chk(8'h04, 32'h4, 32'h4);
		wr(8'h04, 32'hE);
		wr(8'h58, 32'h0);
		go(16'h0060, 1'b1);
		repeat (20) @(posedge mclk);
		halt;
		rd_chk(8'h04, 32'h4, 32'h0);
	endtask

	task t_action;
		wr(8'h58, 32'h0);
		go(16'h0020, 1'b0);
		repeat (5) @(posedge mclk);
		action_req <= 1'b1;
		wait_addr(16'h0220);
		action_req <= 1'b0;
		wait_addr(16'h0020);
		halt;
		rd_chk(8'h58, 32'hFF, 32'h0);
	endtask

	initial begin
		rst_n = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		ce_board = 56'h86858483828180;
		oe_board = 8'h5C;
		wait_entry = 16'h0021;
		action_req = 1'b0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		t_reset;
		t_ptrs;
		t_dispatch;
		t_push;
		t_full;
		t_under;
		t_action;
		end_sim;
	end

	// Whole sequence needs well under a thousand cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		end_sim;
	end
endmodule
`default_nettype wire
